// File: pkg/bcd_pkg.sv
// Shared constants, types and bus carriers for the bounds/clear decoder
package bcd_pkg;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_OPWORD = 8'h04;
   localparam logic [7:0] OFF_CHKVAL = 8'h08;
   localparam logic [7:0] OFF_BOUNDLO = 8'h0c;
   localparam logic [7:0] OFF_BOUNDHI = 8'h10;
   localparam logic [7:0] OFF_CCRIN = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;
   localparam logic [7:0] OFF_RESULT = 8'h1c;

   // ==========================================================
   // Field positions and reset values
   localparam int CTRL_START = 0;
   localparam int CCR_X = 4;
   localparam int CCR_N = 3;
   localparam int CCR_Z = 2;
   localparam int CCR_V = 1;
   localparam int CCR_C = 0;
   localparam int ST_DONE = 8;
   localparam logic [4:0] CCR_RESET = 5'h00;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;
   localparam logic [7:0] TRAP_VECTOR = 8'h06;

   // ==========================================================
   // Opcode fields
   localparam logic [3:0] OPC_BIT_TEST_OP_HI = 4'h0;
   localparam logic [2:0] OPC_BIT_TEST_OP_MID = 3'h4;
   localparam logic [3:0] OPC_CHK_HI = 4'h4;
   localparam logic [4:0] OPC_PAIRED_BOUND_CHECK_HI = 5'h00;
   localparam logic [2:0] OPC_PAIRED_BOUND_CHECK_MID = 3'h3;
   localparam logic [7:0] OPC_CLR_HI = 8'h42;
   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_WORD = 2'h1;
   localparam logic [1:0] SZ_LONG = 2'h2;
   localparam logic [1:0] SZ_BAD = 2'h3;
   localparam logic [2:0] EA_DREG = 3'h0;
   localparam logic [2:0] EA_AREG = 3'h1;
   localparam logic [2:0] EA_POSTINC = 3'h3;
   localparam logic [2:0] EA_PREDEC = 3'h4;
   localparam logic [2:0] EA_EXT = 3'h7;
   localparam logic [2:0] EAX_ABSL = 3'h1;
   localparam logic [2:0] EAX_PCIDX = 3'h3;
   localparam logic [2:0] EAX_IMM = 3'h4;

   // ==========================================================
   // Types
   typedef enum logic {FSM_IDLE, FSM_EXEC} fsm_t;
   typedef enum logic [2:0] {K_NONE, K_BIT_TEST_OP, K_CHK, K_PAIRED_BOUND_CHECK, K_CLR} kind_t;

   typedef struct packed {
      logic hsel;
      logic hready;
      logic [1:0] htrans;
      logic [31:0] haddr;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
   } ahb_req_t;

   typedef struct packed {
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
   } ahb_rsp_t;

   typedef struct packed {
      logic done;
      logic trap;
      logic [7:0] vector;
      logic wrEn;
      logic [1:0] wrSize;
      logic [31:0] wrData;
      logic [4:0] ccr;
   } exec_out_t;

endpackage : bcd_pkg

// File: src/bounds_check_clear_decode.sv
// Decode and execute of bit-test, bound checks and operand clear
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps

// Summary of operation
// - Register bit-test takes bit number from register
// - Bit-test accepts data modes only
// - Register destination long, memory destination byte
// - Single check traps vector 6 out of range
// - Single bound compared as signed value
// - Single check sets N; X kept
// - Single check opcode and size decode
// - Single check bound uses data modes only
// - Paired check traps outside lower/upper bound
// - Lower bound read first, then upper
// - Data register checked on low part
// - Address register: bounds sign-extended, full compare
// - Equal bounds allow exactly one value
// - Paired check sets Z and C; X kept
// - Paired check size and extension word decode
// - Paired check accepts control modes only
// - Clear writes zero, flags N0 Z1 V0 C0
// - Clear opcode and size decode
// - Clear accepts data alterable modes only
module bounds_check_clear_decode #(
   parameter int unsigned ADDR_BITS = 8
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Register bus
   input wire bcd_pkg::ahb_req_t ahbReq,
   output bcd_pkg::ahb_rsp_t ahbRsp,
   // Execution results
   output bcd_pkg::exec_out_t execOut
);

   // ==========================================================
   // Elaboration checks
   if (ADDR_BITS < 5 || ADDR_BITS > 32) begin : g_bad_addr
      $error("ADDR_BITS must be 5 to 32");
   end

   // ==========================================================
   // State
   typedef struct packed {
      bcd_pkg::fsm_t fsm;
      logic dValid;
      logic dWrite;
      logic [5:0] dIdx;
      logic [31:0] opWord;
      logic [31:0] chkVal;
      logic [31:0] boundLo;
      logic [31:0] boundHi;
      logic [4:0] ccrIn;
      bcd_pkg::kind_t kind;
      logic done;
      logic trap;
      logic illegal;
      logic donePulse;
      logic trapPulse;
      logic wrEn;
      logic [1:0] wrSize;
      logic [4:0] ccrOut;
   } state_t;

   state_t q;
   state_t d;

   function automatic logic [5:0] idx(input logic [7:0] off);
      return off[7:2];
   endfunction : idx

   function automatic logic [31:0] widen(input logic [31:0] v, input logic [1:0] sz,
                                         input logic sgn);
      case (sz)
         bcd_pkg::SZ_BYTE: return {{24{sgn & v[7]}}, v[7:0]};
         bcd_pkg::SZ_WORD: return {{16{sgn & v[15]}}, v[15:0]};
         default: return v;
      endcase
   endfunction : widen

   function automatic logic eaData(input logic [2:0] m, input logic [2:0] r);
      return (m != bcd_pkg::EA_AREG) && !(m == bcd_pkg::EA_EXT && r > bcd_pkg::EAX_IMM);
   endfunction : eaData

   function automatic logic eaCtrl(input logic [2:0] m, input logic [2:0] r);
      return (m != bcd_pkg::EA_DREG) && (m != bcd_pkg::EA_AREG) &&
             (m != bcd_pkg::EA_POSTINC) && (m != bcd_pkg::EA_PREDEC) &&
             !(m == bcd_pkg::EA_EXT && r > bcd_pkg::EAX_PCIDX);
   endfunction : eaCtrl

   function automatic logic eaDataAlt(input logic [2:0] m, input logic [2:0] r);
      return (m != bcd_pkg::EA_AREG) && !(m == bcd_pkg::EA_EXT && r > bcd_pkg::EAX_ABSL);
   endfunction : eaDataAlt

   // ==========================================================
   // Decode and datapath
   logic [15:0] op;
   logic [15:0] ext;
   logic [2:0] eaMode;
   logic [2:0] eaReg;
   logic isBtst;
   logic isChk;
   logic isChk2;
   logic isClr;
   bcd_pkg::kind_t decKind;
   logic decIll;
   logic decTrap;
   logic decWr;
   logic [4:0] decCcr;
   logic [4:0] bitIdx;
   logic [1:0] sz;
   logic [31:0] val;
   logic [31:0] lo;
   logic [31:0] hi;
   logic useSigned;
   logic isAddr;
   logic below;
   logic above;

   assign op = q.opWord[15:0];
   assign ext = q.opWord[31:16];
   assign eaMode = op[5:3];
   assign eaReg = op[2:0];
   assign isBtst = op[15:12] == bcd_pkg::OPC_BIT_TEST_OP_HI && op[8:6] == bcd_pkg::OPC_BIT_TEST_OP_MID;
   assign isChk = op[15:12] == bcd_pkg::OPC_CHK_HI && op[8] && !op[6];
   assign isChk2 = op[15:11] == bcd_pkg::OPC_PAIRED_BOUND_CHECK_HI && op[8:6] == bcd_pkg::OPC_PAIRED_BOUND_CHECK_MID &&
                   op[10:9] != bcd_pkg::SZ_BAD && ext[11] && ext[10:0] == 11'h000;
   assign isClr = op[15:8] == bcd_pkg::OPC_CLR_HI && op[7:6] != bcd_pkg::SZ_BAD;
   assign isAddr = ext[15];

   always_comb begin
      decKind = bcd_pkg::K_NONE;
      decIll = 1'b1;
      decTrap = 1'b0;
      decWr = 1'b0;
      decCcr = q.ccrIn;
      bitIdx = 5'h00;
      sz = bcd_pkg::SZ_LONG;
      val = q.chkVal;
      lo = q.boundLo;
      hi = q.boundHi;
      useSigned = 1'b1;
      below = 1'b0;
      above = 1'b0;
      if (isBtst) begin
         decKind = bcd_pkg::K_BIT_TEST_OP;
         decIll = !eaData(eaMode, eaReg);
         // Register destination: modulo 32; memory: byte, modulo 8
         bitIdx = (eaMode == bcd_pkg::EA_DREG) ? q.chkVal[4:0] : {2'b00, q.chkVal[2:0]};
         decCcr[bcd_pkg::CCR_Z] = ~q.boundLo[bitIdx];
      end else if (isChk) begin
         decKind = bcd_pkg::K_CHK;
         decIll = !eaData(eaMode, eaReg);
         sz = op[7] ? bcd_pkg::SZ_WORD : bcd_pkg::SZ_LONG;
         val = widen(q.chkVal, sz, 1'b1);
         lo = widen(q.boundLo, sz, 1'b1);
         below = $signed(val) < 0;
         above = $signed(val) > $signed(lo);
         decTrap = below | above;
         // Z, V, C undefined: left as they came in
         if (below) begin
            decCcr[bcd_pkg::CCR_N] = 1'b1;
         end else if (above) begin
            decCcr[bcd_pkg::CCR_N] = 1'b0;
         end
      end else if (isChk2) begin
         decKind = bcd_pkg::K_PAIRED_BOUND_CHECK;
         decIll = !eaCtrl(eaMode, eaReg);
         sz = op[10:9];
         // Bounds ordered unsigned select an unsigned check, else signed
         lo = widen(q.boundLo, sz, isAddr);
         hi = widen(q.boundHi, sz, isAddr);
         useSigned = lo > hi;
         lo = widen(q.boundLo, sz, isAddr | useSigned);
         hi = widen(q.boundHi, sz, isAddr | useSigned);
         val = isAddr ? q.chkVal : widen(q.chkVal, sz, useSigned);
         below = useSigned ? ($signed(val) < $signed(lo)) : (val < lo);
         above = useSigned ? ($signed(val) > $signed(hi)) : (val > hi);
         decTrap = below | above;
         decCcr[bcd_pkg::CCR_Z] = (val == lo) || (val == hi);
         decCcr[bcd_pkg::CCR_C] = below | above;
      end else if (isClr) begin
         decKind = bcd_pkg::K_CLR;
         decIll = !eaDataAlt(eaMode, eaReg);
         decWr = 1'b1;
         decCcr[bcd_pkg::CCR_N] = 1'b0;
         decCcr[bcd_pkg::CCR_Z] = 1'b1;
         decCcr[bcd_pkg::CCR_V] = 1'b0;
         decCcr[bcd_pkg::CCR_C] = 1'b0;
      end
      // A rejected encoding touches nothing
      if (decIll) begin
         decTrap = 1'b0;
         decWr = 1'b0;
         decCcr = q.ccrIn;
      end
   end

   // ==========================================================
   // Next state: bus slave and sequencer
   // Addresses past the decoded window read as unmapped rather than aliasing
   logic inWindow;
   assign inWindow = (ahbReq.haddr >> ADDR_BITS) == 32'h0000_0000;

   always_comb begin
      d = q;
      d.donePulse = 1'b0;
      d.trapPulse = 1'b0;
      if (ahbReq.hready) begin
         d.dValid = ahbReq.hsel && ahbReq.htrans[1] && inWindow;
         d.dWrite = ahbReq.hwrite;
         d.dIdx = ahbReq.haddr[7:2];
      end
      if (q.dValid && q.dWrite) begin
         case (q.dIdx)
            idx(bcd_pkg::OFF_CTRL): begin
               // Start during execution is ignored
               if (ahbReq.hwdata[bcd_pkg::CTRL_START] && q.fsm == bcd_pkg::FSM_IDLE) begin
                  d.fsm = bcd_pkg::FSM_EXEC;
                  d.done = 1'b0;
               end
            end
            idx(bcd_pkg::OFF_OPWORD): d.opWord = ahbReq.hwdata;
            idx(bcd_pkg::OFF_CHKVAL): d.chkVal = ahbReq.hwdata;
            idx(bcd_pkg::OFF_BOUNDLO): d.boundLo = ahbReq.hwdata;
            idx(bcd_pkg::OFF_BOUNDHI): d.boundHi = ahbReq.hwdata;
            idx(bcd_pkg::OFF_CCRIN): d.ccrIn = ahbReq.hwdata[4:0];
            idx(bcd_pkg::OFF_STATUS): begin
               if (ahbReq.hwdata[bcd_pkg::ST_DONE]) begin
                  d.done = 1'b0;
               end
            end
            default: ;
         endcase
      end
      case (q.fsm)
         bcd_pkg::FSM_EXEC: begin
            // Completion set comes last so it beats a same-cycle clear
            d.fsm = bcd_pkg::FSM_IDLE;
            d.done = 1'b1;
            d.donePulse = 1'b1;
            d.kind = decKind;
            d.illegal = decIll;
            d.trap = decTrap;
            d.trapPulse = decTrap;
            d.ccrOut = decCcr;
            d.wrEn = decWr;
            d.wrSize = op[7:6];
         end
         default: ;
      endcase
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         q <= '{fsm: bcd_pkg::FSM_IDLE, kind: bcd_pkg::K_NONE, dIdx: 6'h00,
                opWord: bcd_pkg::WORD_RESET, chkVal: bcd_pkg::WORD_RESET,
                boundLo: bcd_pkg::WORD_RESET, boundHi: bcd_pkg::WORD_RESET,
                ccrIn: bcd_pkg::CCR_RESET, ccrOut: bcd_pkg::CCR_RESET,
                wrSize: 2'h0, default: 1'b0};
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // Outputs
   logic [31:0] rdMux;

   always_comb begin
      rdMux = 32'h0000_0000;
      if (q.dValid && !q.dWrite) begin
         case (q.dIdx)
            idx(bcd_pkg::OFF_CTRL): rdMux = {31'h0000_0000, q.fsm == bcd_pkg::FSM_EXEC};
            idx(bcd_pkg::OFF_OPWORD): rdMux = q.opWord;
            idx(bcd_pkg::OFF_CHKVAL): rdMux = q.chkVal;
            idx(bcd_pkg::OFF_BOUNDLO): rdMux = q.boundLo;
            idx(bcd_pkg::OFF_BOUNDHI): rdMux = q.boundHi;
            idx(bcd_pkg::OFF_CCRIN): rdMux = {27'h000_0000, q.ccrIn};
            idx(bcd_pkg::OFF_STATUS): begin
               rdMux = {8'h00, q.trap ? bcd_pkg::TRAP_VECTOR : 8'h00, 1'b0, q.kind,
                        1'b0, q.illegal, q.trap, q.done, 3'h0, q.ccrOut};
            end
            idx(bcd_pkg::OFF_RESULT): rdMux = {29'h0000_0000, q.wrEn, q.wrSize};
            default: rdMux = 32'h0000_0000;
         endcase
      end
   end

   // Zero wait states, so every access answers OKAY at once
   assign ahbRsp.hrdata = rdMux;
   assign ahbRsp.hreadyout = 1'b1;
   assign ahbRsp.hresp = 1'b0;

   assign execOut.done = q.donePulse;
   assign execOut.trap = q.trapPulse;
   assign execOut.vector = q.trapPulse ? bcd_pkg::TRAP_VECTOR : 8'h00;
   assign execOut.wrEn = q.donePulse & q.wrEn;
   assign execOut.wrSize = q.wrSize;
   assign execOut.wrData = 32'h0000_0000;
   assign execOut.ccr = q.ccrOut;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   logic execNow;
   assign execNow = q.fsm == bcd_pkg::FSM_EXEC;

   sequence sStart;
      q.dValid && q.dWrite && q.dIdx == idx(bcd_pkg::OFF_CTRL) &&
      ahbReq.hwdata[bcd_pkg::CTRL_START] && !execNow;
   endsequence

   sequence sRunDone;
      execNow ##1 (execOut.done && !execNow);
   endsequence

   a_start_done_seq: assert property (sStart |=> sRunDone)
      else $error("start did not complete in two cycles");

   a_trap_vector: assert property (execOut.trap |-> execOut.vector == 8'h06 && execOut.done)
      else $error("trap without vector 6");

   a_chk_negative: assert property (execNow && isChk && !decIll && !op[7] &&
      q.chkVal[31] |=> execOut.trap && execOut.ccr[3])
      else $error("negative register not trapped with N set");

   a_chk_word_sign: assert property (execNow && isChk && !decIll && op[7] &&
      q.chkVal[15] |=> execOut.trap)
      else $error("word check ignored sign of low word");

   a_paired_bound_check_equal_bounds: assert property (execNow && isChk2 && !decIll &&
      q.boundLo == q.boundHi && op[10:9] == 2'h2 |=>
      execOut.trap == ($past(q.chkVal) != $past(q.boundLo)))
      else $error("equal bounds range not a single value");

   a_paired_bound_check_carry_trap: assert property (execOut.done && q.kind == bcd_pkg::K_PAIRED_BOUND_CHECK &&
      !q.illegal |-> execOut.ccr[0] == execOut.trap)
      else $error("carry does not match out of bounds");

   a_clear_flags: assert property (execNow && isClr && !decIll |=>
      execOut.ccr[3:0] == 4'h4 && execOut.wrEn && execOut.wrData == 32'h0)
      else $error("clear flags or write wrong");

   a_clear_areg_reject: assert property (execNow && isClr && eaMode == 3'h1 |=>
      q.illegal && !execOut.wrEn)
      else $error("clear accepted address register direct");

   a_paired_bound_check_reject_mode: assert property (execNow && isChk2 && (eaMode == 3'h3 ||
      eaMode == 3'h4 || eaMode == 3'h0) |=> q.illegal && !execOut.trap)
      else $error("paired check accepted bad mode");

   a_bit_test_op_long_bit: assert property (execNow && isBtst && eaMode == 3'h0 |=>
      execOut.ccr[2] == !$past(q.boundLo[q.chkVal[4:0]]))
      else $error("register bit test Z wrong");

   a_extend_kept: assert property (execOut.done |-> execOut.ccr[4] == q.ccrIn[4])
      else $error("extend flag changed");

   logic chkFits;
   assign chkFits = execNow && isChk && !decIll && !op[7] && !q.chkVal[31] &&
                    $signed(q.chkVal) <= $signed(q.boundLo);

   a_chk_in_range: assert property (chkFits |=> !execOut.trap)
      else $error("in-range register trapped");

   a_reject_inert: assert property (execOut.done && q.illegal |->
      !execOut.trap && !execOut.wrEn)
      else $error("rejected encoding trapped or wrote");

endmodule : bounds_check_clear_decode

// File: verification/exec_sink.sv
// Result sink standing in for operand fetch and exception sequencing
`timescale 1ns/100ps
module exec_sink (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Results from the decoder
   input wire bcd_pkg::exec_out_t execOut,
   // Event counts for the bench
   output int nDone,
   output int nTrap,
   output int nBad
);
   // ==========
   // Event capture
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         nDone <= 0;
         nTrap <= 0;
         nBad <= 0;
      end else begin
         nDone <= nDone + int'(execOut.done);
         nTrap <= nTrap + int'(execOut.trap);
         // A stray trap or write would start a bogus exception or bus cycle
         if ((execOut.trap && (!execOut.done || execOut.vector !== bcd_pkg::TRAP_VECTOR))
               || (execOut.wrEn && (!execOut.done || execOut.trap))) begin
            nBad <= nBad + 1;
         end
      end
   end
endmodule : exec_sink

// File: verification/test_bounds_check_clear_decode.sv
// Self-checking bench for the bounds check and clear decoder
`timescale 1ns/100ps
module test_bounds_check_clear_decode;
   bcd_pkg::ahb_req_t req;
   bcd_pkg::ahb_rsp_t rsp;
   bcd_pkg::ahb_rsp_t rspQ;
   bcd_pkg::exec_out_t ex;
   bcd_pkg::exec_out_t exQ;
   wire bcd_pkg::ahb_req_t dutReq;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic [31:0] q;
   int mismatches = 0;
   int n_checks = 0;
   int expDone = 0;
   int expTrap = 0;
   int nDone;
   int nTrap;
   int nBad;

   // ==========
   // Clock, hready loop and edge sampling
   always #4 mclk = ~mclk;
   assign dutReq = {req.hsel, rsp.hreadyout, req[69:0]};
   always @(posedge mclk) begin
      rspQ <= rsp;
      exQ <= ex;
   end

   bounds_check_clear_decode #(.ADDR_BITS(8)) dut (.mclk(mclk), .resetn(resetn),
      .ahbReq(dutReq), .ahbRsp(rsp), .execOut(ex));
   exec_sink sink (.mclk(mclk), .resetn(resetn), .execOut(ex), .nDone(nDone),
      .nTrap(nTrap), .nBad(nBad));

   // ==========
   // Helpers
   task automatic give_verdict;
      if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : give_verdict

   task automatic cmp(input string nm, input logic [31:0] want, got);
      n_checks++;
      if (got !== want) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, want, got);
      end
   endtask : cmp

   task automatic tick;
      @(posedge mclk);
      #1;
   endtask : tick

   // Values seen at an edge come from rspQ, the pre-edge copy
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] rd);
      req.hsel <= 1'b1;
      req.htrans <= 2'h2;
      req.haddr <= {24'h0, a};
      req.hwrite <= wr;
      req.hsize <= 3'h2;
      do tick(); while (rspQ.hreadyout !== 1'b1);
      req.hsel <= 1'b0;
      req.htrans <= 2'h0;
      req.hwdata <= d;
      do tick(); while (rspQ.hreadyout !== 1'b1);
      rd = rspQ.hrdata;
      cmp("hresp", 32'h0, {31'h0, rspQ.hresp});
   endtask : bus

   function automatic longint sx(input logic [31:0] v, input logic [1:0] sz, input logic sg);
      case (sz)
         2'h0: sx = sg ? longint'($signed(v[7:0])) : longint'(v[7:0]);
         2'h1: sx = sg ? longint'($signed(v[15:0])) : longint'(v[15:0]);
         default: sx = sg ? longint'($signed(v)) : longint'(v);
      endcase
   endfunction : sx

   task automatic model(input logic [31:0] op, c, lo, hi, input logic [4:0] cc,
         output logic [4:0] e, output logic t, il, w, output logic [2:0] kd);
      logic [15:0] o;
      logic [2:0] m;
      logic [2:0] r;
      logic [1:0] s;
      logic a;
      logic sg;
      longint rv;
      longint lv;
      longint hv;
      o = op[15:0];
      m = o[5:3];
      r = o[2:0];
      s = o[10:9];
      a = op[31];
      e = cc;
      t = 1'b0;
      w = 1'b0;
      il = 1'b1;
      kd = 3'h0;
      if (o[15:12] == 4'h0 && o[8:6] == 3'h4) begin
         kd = 3'h1;
         il = m == 3'h1 || (m == 3'h7 && r > 3'h4);
         e[2] = (m == 3'h0) ? ~lo[c[4:0]] : ~lo[c[2:0]];
      end else if (o[15:12] == 4'h4 && o[8] && !o[6]) begin
         kd = 3'h2;
         il = m == 3'h1 || (m == 3'h7 && r > 3'h4);
         rv = sx(c, o[7] ? 2'h1 : 2'h2, 1'b1);
         hv = sx(lo, o[7] ? 2'h1 : 2'h2, 1'b1);
         t = rv < 0 || rv > hv;
         if (rv < 0) e[3] = 1'b1;
         else if (rv > hv) e[3] = 1'b0;
      end else if (o[15:11] == 5'h0 && o[8:6] == 3'h3 && s != 2'h3 && op[27] &&
            op[26:16] == 11'h000) begin
         kd = 3'h3;
         il = !(m == 3'h2 || m == 3'h5 || m == 3'h6 || (m == 3'h7 && r < 3'h4));
         sg = sx(lo, s, 1'b0) > sx(hi, s, 1'b0);
         lv = sx(lo, s, a | sg);
         hv = sx(hi, s, a | sg);
         rv = sx(c, a ? 2'h2 : s, sg);
         if (!sg) begin
            lv = lv & 64'hffffffff;
            hv = hv & 64'hffffffff;
         end
         t = rv < lv || rv > hv;
         e[0] = t;
         e[2] = rv == lv || rv == hv;
      end else if (o[15:8] == 8'h42 && o[7:6] != 2'h3) begin
         kd = 3'h4;
         il = m == 3'h1 || (m == 3'h7 && r > 3'h1);
         w = 1'b1;
         e = {cc[4], 4'h4};
      end
      if (il) begin
         e = cc;
         t = 1'b0;
         w = 1'b0;
      end
   endtask : model

   task automatic run(input logic [31:0] op, c, lo, hi);
      logic [4:0] cc;
      logic [4:0] e;
      logic t;
      logic il;
      logic w;
      logic [2:0] kd;
      int k;
      cc = 5'($urandom);
      model(op, c, lo, hi, cc, e, t, il, w, kd);
      bus(1'b1, bcd_pkg::OFF_OPWORD, op, q);
      bus(1'b1, bcd_pkg::OFF_CHKVAL, c, q);
      bus(1'b1, bcd_pkg::OFF_BOUNDLO, lo, q);
      bus(1'b1, bcd_pkg::OFF_BOUNDHI, hi, q);
      bus(1'b1, bcd_pkg::OFF_CCRIN, {27'h0, cc}, q);
      bus(1'b1, bcd_pkg::OFF_CTRL, 32'h1, q);
      k = 0;
      while (exQ.done !== 1'b1 && k < 8) begin
         tick();
         k++;
      end
      expDone++;
      expTrap += int'(t);
      cmp("latency", 32'd2, 32'(k));
      cmp("trap", {31'h0, t}, {31'h0, exQ.trap});
      cmp("vector", t ? 32'h6 : 32'h0, {24'h0, exQ.vector});
      cmp("write", {31'h0, w}, {31'h0, exQ.wrEn});
      cmp("size", {30'h0, op[7:6]}, {30'h0, exQ.wrSize});
      cmp("wdata", 32'h0, exQ.wrData);
      cmp("ccr", {27'h0, e}, {27'h0, exQ.ccr});
      tick();
      cmp("pulse", 32'h0, {30'h0, exQ.done, exQ.trap});
      bus(1'b0, bcd_pkg::OFF_STATUS, 32'h0, q);
      cmp("status", {8'h0, t ? 8'h6 : 8'h0, 1'b0, kd, 1'b0, il, t, 1'b1, 3'h0, e},
         q);
      bus(1'b0, bcd_pkg::OFF_RESULT, 32'h0, q);
      cmp("result", {29'h0, w, op[7:6]}, q);
   endtask : run

   // ==========
   // Main sequence and watchdog
   initial begin
      repeat (30000) @(posedge mclk);
      mismatches++;
      give_verdict();
   end

   initial begin
      logic [31:0] op;
      logic [31:0] lo;
      logic [31:0] hi;
      logic [2:0] m;
      logic [2:0] r;
      logic [1:0] s;
      req = '0;
      void'($urandom(32'hac82f403));
      repeat (20) tick();
      resetn <= 1'b1;
      for (int a = 0; a < 36; a += 4) begin
         bus(1'b0, 8'(a), 32'h0, q);
         cmp("reset value", 32'h0, q);
      end
      bus(1'b1, 8'h20, 32'hffffffff, q);
      bus(1'b0, 8'h20, 32'h0, q);
      cmp("unmapped", 32'h0, q);
      op = $urandom;
      bus(1'b1, bcd_pkg::OFF_BOUNDHI, op, q);
      bus(1'b0, bcd_pkg::OFF_BOUNDHI, 32'h0, q);
      cmp("readback", op, q);
      run(32'h00004180, 32'hffff8000, 32'h00007fff, 32'h0);
      run(32'h00004180, 32'h00010005, 32'h00000005, 32'h0);
      run(32'h00004100, 32'h00000006, 32'h00000005, 32'h0);
      run(32'h00004188, 32'h00000001, 32'h00000005, 32'h0);
      run(32'h880000d0, 32'hffffff80, 32'h00000080, 32'h7f);
      run(32'h880000d0, 32'h00000080, 32'h00000080, 32'h7f);
      run(32'h080000d0, 32'h12345680, 32'h00000080, 32'h7f);
      run(32'h080002d0, 32'h00001234, 32'h00001234, 32'h1234);
      run(32'h080002d0, 32'h00001235, 32'h00001234, 32'h1234);
      for (int i = 0; i < 2; i++) begin
         run(32'h080004d0, 32'h80000000 + i, 32'h80000000, 32'h80000000);
      end
      run(32'h080000d8, 32'h0, 32'h0, 32'h0);
      run(32'h00000100, 32'd31, 32'h80000000, 32'h0);
      run(32'h00000110, 32'h0000000f, 32'h00000080, 32'h0);
      run(32'h00000108, 32'h0, 32'h0, 32'h0);
      for (int i = 0; i < 3; i++) run({24'h42, 2'(i), 6'h0}, 32'h0, 32'h0, 32'h0);
      run(32'h0000423a, 32'h0, 32'h0, 32'h0);
      for (int i = 0; i < 150; i++) begin
         m = 3'($urandom);
         r = 3'($urandom);
         s = 2'($urandom_range(0, 2));
         lo = $urandom;
         hi = $urandom;
         case ($urandom_range(0, 3))
            0: op = {20'h0, 3'($urandom), 3'h4, m, r};
            1: op = {20'h4, 3'($urandom), 1'b1, s[0], 1'b0, m, (m == 7 && r == 4) ? 3'h3 : r};
            2: op = {1'($urandom), 3'($urandom), 1'b1, 16'h0, s, 3'h3, m, r};
            default: op = {24'h42, s, m, r};
         endcase
         run(op, (i % 3 == 0) ? lo : (i % 3 == 1) ? hi : $urandom, lo, hi);
      end
      // Back-to-back starts: execution ends before the second data phase, so both run
      bus(1'b1, bcd_pkg::OFF_OPWORD, 32'h0000_4200, q);
      bus(1'b1, bcd_pkg::OFF_CTRL, 32'h1, q);
      bus(1'b1, bcd_pkg::OFF_CTRL, 32'h1, q);
      repeat (6) tick();
      expDone += 2;
      cmp("done count", 32'(expDone), 32'(nDone));
      cmp("trap count", 32'(expTrap), 32'(nTrap));
      cmp("sink faults", 32'h0, 32'(nBad));
      bus(1'b1, bcd_pkg::OFF_STATUS, 32'h100, q);
      bus(1'b0, bcd_pkg::OFF_STATUS, 32'h0, q);
      cmp("done clear", 32'h0, q & 32'h100);
      resetn <= 1'b0;
      repeat (3) tick();
      resetn <= 1'b1;
      bus(1'b0, bcd_pkg::OFF_OPWORD, 32'h0, q);
      cmp("second reset", 32'h0, q);
      give_verdict();
   end
endmodule : test_bounds_check_clear_decode
